// ---- src/eeprom_dev_end.sv ----
// EEPROM slave end: two-wire decode, page buffer, programming timer, array.
// Assumes the link and straps are asynchronous to clk_in; no clock stretching.
`timescale 1ns/100ps
`default_nettype none
module eeprom_dev_end #(
   parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES
) (
   input  wire logic    clk_in,
   input  wire logic    nrst_in,
   input  wire logic    select_pin_bit0_in,
   input  wire logic    select_pin_bit1_in,
   input  wire logic    select_pin_bit2_in,
   input  wire logic    write_protect_in,
   output logic         prog_busy_out,
   eeprom_link_if.device link
);
   typedef enum {
      ST_IDLE,
      ST_DEV,
      ST_MHI,
      ST_MLO,
      ST_WDATA,
      ST_READ,
      ST_IGNORE
   } dev_state_t;

   logic [5:0]  pins_s;
   logic        scl_s;
   logic        sda_s;
   logic        wp_s;
   logic [2:0]  sel_s;
   logic        scl_d;
   logic        sda_d;
   dev_state_t  state;
   dev_state_t  next_state;
   logic [3:0]  bitcnt;
   logic [7:0]  shreg;
   logic [7:0]  tx;
   logic        drive;
   logic        next_drive;
   logic [eeprom_pkg::ADDR_W-1:0] addr;
   logic [7:0]  mem [eeprom_pkg::MEM_BYTES];
   logic [7:0]  pagebuf [eeprom_pkg::PAGE_BYTES];
   logic [eeprom_pkg::PAGE_BYTES-1:0] mask;
   logic        busy;
   logic [31:0] prog_cnt;
   logic [eeprom_pkg::PAGE_BITS-1:0] prog_idx;

   pin_sync #(.WIDTH(6)) u_sync (
      .clk_in  (clk_in),
      .nrst_in (nrst_in),
      .d_in    ({link.scl, link.sda, write_protect_in,
                 select_pin_bit2_in, select_pin_bit1_in, select_pin_bit0_in}),
      .q_out   (pins_s)
   );
   assign scl_s = pins_s[5];
   assign sda_s = pins_s[4];
   assign wp_s  = pins_s[3];
   // A floating strap must be pulled low outside; it then reads as zero
   assign sel_s = pins_s[2:0];

   // Edge and condition detection on the synchronised lines
   wire scl_rise  = scl_s & ~scl_d;
   wire scl_fall  = ~scl_s & scl_d;
   wire start_det = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_det  = scl_s & scl_d & ~sda_d & sda_s;
   wire ack_slot  = scl_fall & (bitcnt == eeprom_pkg::ACK_IDX);
   wire ack_rise  = scl_rise & (bitcnt == eeprom_pkg::ACK_IDX);

   // Address word decode
   wire type_ok = shreg[eeprom_pkg::TYPE_MSB:eeprom_pkg::TYPE_LSB]
                  == eeprom_pkg::DEVICE_TYPE_CODE;
   wire sel_ok  = shreg[eeprom_pkg::SEL_MSB:eeprom_pkg::SEL_LSB] == sel_s;
   wire dev_ok  = type_ok & sel_ok & ~busy;
   wire is_read = shreg[eeprom_pkg::RW_BIT];

   wire in_dev   = state == ST_DEV;
   wire in_madr  = (state == ST_MHI) | (state == ST_MLO);
   wire in_wdata = state == ST_WDATA;
   wire in_read  = state == ST_READ;

   // Write protect refuses the first data byte and all after it
   wire accept_data = ack_slot & in_wdata & ~wp_s;
   wire ack_give    = ack_slot & ((in_dev & dev_ok) | in_madr | accept_data);
   // Our own address acknowledge reads as zero here, so it fetches the first byte
   wire read_load   = ack_rise & in_read & ~sda_s;
   wire master_nack = ack_rise & in_read & sda_s;
   wire prog_start  = stop_det & in_wdata & (|mask) & ~busy;
   wire prog_last   = busy & (prog_cnt == 32'(PROG_CYCLES - 1));
   wire commit      = busy & (prog_cnt < eeprom_pkg::PAGE_BYTES_W);
   assign prog_idx  = prog_cnt[eeprom_pkg::PAGE_BITS-1:0];

   always_comb begin
      next_state = state;
      if (start_det) begin
         next_state = ST_DEV;
      end else if (stop_det) begin
         next_state = ST_IDLE;
      end else if (ack_slot) begin
         unique case (state)
            ST_DEV:    next_state = !dev_ok ? ST_IGNORE : (is_read ? ST_READ : ST_MHI);
            ST_MHI:    next_state = ST_MLO;
            ST_MLO:    next_state = ST_WDATA;
            ST_WDATA:  next_state = wp_s ? ST_IGNORE : ST_WDATA;
            ST_IDLE:   next_state = state;
            ST_READ:   next_state = state;
            ST_IGNORE: next_state = state;
         endcase
      end else if (master_nack) begin
         next_state = ST_IGNORE;
      end
   end

   // Drive only right after an SCL fall; release on start and stop
   always_comb begin
      next_drive = drive;
      if (start_det | stop_det) begin
         next_drive = 1'h0;
      end else if (scl_fall) begin
         if (bitcnt == eeprom_pkg::ACK_IDX) begin
            next_drive = ack_give;
         end else if (in_read) begin
            next_drive = ~tx[~bitcnt[2:0]];
         end else begin
            next_drive = 1'h0;
         end
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         scl_d <= 1'h1;
         sda_d <= 1'h1;
         state <= ST_IDLE;
         drive <= 1'h0;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
         state <= next_state;
         drive <= next_drive;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         bitcnt <= 4'h0;
         shreg  <= 8'h00;
      end else if (start_det) begin
         bitcnt <= 4'h0;
      end else if (scl_rise & (state != ST_IDLE)) begin
         bitcnt <= (bitcnt == eeprom_pkg::ACK_IDX) ? 4'h0 : bitcnt + 4'h1;
         if (bitcnt != eeprom_pkg::ACK_IDX) begin
            shreg <= {shreg[6:0], sda_s};
         end
      end
   end

   // Address counter: full increment on reads, page offset only on writes
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         addr <= '0;
         tx   <= 8'h00;
      end else if (ack_slot & (state == ST_MHI)) begin
         addr[eeprom_pkg::ADDR_W-1:8] <= shreg[eeprom_pkg::MADDR_HI_MSB:0];
      end else if (ack_slot & (state == ST_MLO)) begin
         addr[7:0] <= shreg;
      end else if (accept_data) begin
         addr[eeprom_pkg::PAGE_BITS-1:0] <= addr[eeprom_pkg::PAGE_BITS-1:0] + 6'h01;
      end else if (read_load) begin
         tx   <= mem[addr];
         addr <= addr + 15'h0001;
      end
   end

   always_ff @(posedge clk_in) begin
      if (accept_data) begin
         pagebuf[addr[eeprom_pkg::PAGE_BITS-1:0]] <= shreg;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mask <= '0;
      end else if ((ack_slot & (state == ST_MLO)) | prog_last) begin
         mask <= '0;
      end else if (accept_data) begin
         mask[addr[eeprom_pkg::PAGE_BITS-1:0]] <= 1'h1;
      end
   end

   // Programming timer; the page is committed in its first 64 cycles
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         busy     <= 1'h0;
         prog_cnt <= 32'h0;
      end else if (prog_start) begin
         busy     <= 1'h1;
         prog_cnt <= 32'h0;
      end else if (busy) begin
         busy     <= ~prog_last;
         prog_cnt <= prog_cnt + 32'h1;
      end
   end

   // All loaded bytes of the page land in one programming cycle
   always_ff @(posedge clk_in) begin
      if (commit & mask[prog_idx]) begin
         mem[{addr[eeprom_pkg::ADDR_W-1:eeprom_pkg::PAGE_BITS], prog_idx}] <= pagebuf[prog_idx];
      end
   end

   assign prog_busy_out     = busy;
   assign link.dev_sda_o    = 1'h0;
   assign link.dev_sda_oe_n = ~drive;
endmodule // eeprom_dev_end
`default_nettype wire

// ---- src/eeprom_pkg.sv ----
// Shared constants for the two-wire EEPROM slave end and its bus master end.
// Assumes a single 10 MHz system clock on both ends.
`default_nettype none
package eeprom_pkg;
   localparam int CLK_PERIOD_NS = 100;
   // Programming cycle, longest time, so the count rounds down
   localparam int PROG_TIME_MS  = 5;
   localparam int PROG_CYCLES   = (PROG_TIME_MS * 1000000) / CLK_PERIOD_NS;
   // Quarter of an SCL period made by the master, least time, rounds up
   localparam int SCL_QTR_NS    = 700;
   localparam int QTR_CYCLES    = (SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] QTR_LAST = 4'(QTR_CYCLES - 1);

   localparam int ADDR_W     = 15;
   localparam int MEM_BYTES  = 32768;
   localparam int PAGE_BITS  = 6;
   localparam int PAGE_BYTES = 64;
   localparam logic [31:0] PAGE_BYTES_W = 32'h40;

   // Device-type code in the upper nibble of the address word; value is arbitrary
   localparam logic [3:0] DEVICE_TYPE_CODE = 4'h6;
   localparam int TYPE_MSB = 7;
   localparam int TYPE_LSB = 4;
   localparam int SEL_MSB  = 3;
   localparam int SEL_LSB  = 1;
   localparam int RW_BIT   = 0;
   localparam int MADDR_HI_MSB = 6;

   // Bit counter value after the eighth rising edge: the acknowledge slot
   localparam logic [3:0] ACK_IDX = 4'h8;

   localparam logic [5:0] SYNC_RESET = 6'h00;

   typedef enum logic [1:0] {
      OP_START,
      OP_STOP,
      OP_WRITE,
      OP_READ
   } op_t;
endpackage
`default_nettype wire

// ---- src/eeprom_link_if.sv ----
// Two-wire link between the bus master end and the EEPROM slave end.
// Both lines are open drain with pull-ups; the wire level is resolved here.
`timescale 1ns/100ps
`default_nettype none
interface eeprom_link_if;
   logic host_scl_o;
   logic host_scl_oe_n;
   logic host_sda_o;
   logic host_sda_oe_n;
   logic dev_sda_o;
   logic dev_sda_oe_n;
   logic scl;
   logic sda;

   // Wired-AND: a released driver reads as the pull-up level
   assign scl = host_scl_oe_n ? 1'h1 : host_scl_o;
   assign sda = (host_sda_oe_n ? 1'h1 : host_sda_o) & (dev_sda_oe_n ? 1'h1 : dev_sda_o);

   modport device (
      input  scl,
      input  sda,
      output dev_sda_o,
      output dev_sda_oe_n
   );
   modport host (
      input  scl,
      input  sda,
      output host_scl_o,
      output host_scl_oe_n,
      output host_sda_o,
      output host_sda_oe_n
   );
endinterface
`default_nettype wire

// ---- src/pin_sync.sv ----
// Two-flop synchroniser for asynchronous pins.
// Assumes each bit is an independent level; no multi-bit coherency.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_in,
   input  wire logic             nrst_in,
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         meta  <= '0;
         q_out <= '0;
      end else begin
         meta  <= d_in;
         q_out <= meta;
      end
   end
endmodule // pin_sync
`default_nettype wire

// ---- src/bus_master_end.sv ----
// Two-wire bus master end: byte-level start, stop, write and read commands.
// Assumes a single master on the bus and no clock stretching by the slave.
`timescale 1ns/100ps
`default_nettype none
module bus_master_end (
   input  wire logic             clk_in,
   input  wire logic             nrst_in,
   input  wire logic             cmd_valid_in,
   output logic                  cmd_ready_out,
   input  wire eeprom_pkg::op_t  cmd_op_in,
   input  wire logic [7:0]       cmd_data_in,
   input  wire logic             cmd_nack_in,
   output logic                  rsp_valid_out,
   output logic [7:0]            rsp_data_out,
   output logic                  rsp_ack_bit_out,
   eeprom_link_if.host           link
);
   typedef enum {
      H_IDLE,
      H_START,
      H_STOP,
      H_BYTE
   } host_state_t;

   host_state_t      state;
   eeprom_pkg::op_t  op;
   logic [3:0]  div;
   logic [1:0]  qtr;
   logic [3:0]  bitn;
   logic [7:0]  shreg;
   logic        nack;
   logic        ack_bit;
   logic        scl_rel;
   logic        sda_low;
   logic        sda_s;

   pin_sync #(.WIDTH(1)) u_sync (
      .clk_in  (clk_in),
      .nrst_in (nrst_in),
      .d_in    (link.sda),
      .q_out   (sda_s)
   );

   assign cmd_ready_out = state == H_IDLE;
   wire accept   = cmd_valid_in & cmd_ready_out;
   wire tick     = (state != H_IDLE) & (div == eeprom_pkg::QTR_LAST);
   wire ack_bitn = bitn == eeprom_pkg::ACK_IDX;
   wire is_write = op == eeprom_pkg::OP_WRITE;
   // Low on a zero data bit we send, or on our own acknowledge of a read byte
   wire bit_low  = ack_bitn ? (~is_write & ~nack) : (is_write & ~shreg[7]);
   wire done     = tick & (qtr == 2'h3) & ((state != H_BYTE) | ack_bitn);

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         div <= 4'h0;
         qtr <= 2'h0;
      end else if (accept | tick) begin
         div <= 4'h0;
         qtr <= accept ? 2'h0 : qtr + 2'h1;
      end else begin
         div <= div + 4'h1;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state <= H_IDLE;
         op    <= eeprom_pkg::OP_START;
         nack  <= 1'h0;
      end else if (accept) begin
         op    <= cmd_op_in;
         nack  <= cmd_nack_in;
         unique case (cmd_op_in)
            eeprom_pkg::OP_START: state <= H_START;
            eeprom_pkg::OP_STOP:  state <= H_STOP;
            eeprom_pkg::OP_WRITE: state <= H_BYTE;
            eeprom_pkg::OP_READ:  state <= H_BYTE;
         endcase
      end else if (done) begin
         state <= H_IDLE;
      end
   end

   // Quarter 0 sets data with SCL low, 1 raises SCL, 2 samples, 3 lowers SCL except in a stop
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         scl_rel <= 1'h1;
         sda_low <= 1'h0;
      end else if (tick) begin
         unique case (qtr)
            2'h0: sda_low <= (state == H_STOP) | ((state == H_BYTE) & bit_low);
            2'h1: scl_rel <= 1'h1;
            2'h2: sda_low <= (state == H_START) ? 1'h1 : ((state == H_STOP) ? 1'h0 : sda_low);
            2'h3: scl_rel <= state == H_STOP;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         bitn    <= 4'h0;
         shreg   <= 8'h00;
         ack_bit <= 1'h1;
      end else if (accept) begin
         bitn    <= 4'h0;
         shreg   <= cmd_data_in;
      end else if (tick & (state == H_BYTE)) begin
         if ((qtr == 2'h2) & ~ack_bitn) begin
            shreg <= {shreg[6:0], sda_s};
         end
         if ((qtr == 2'h2) & ack_bitn) begin
            ack_bit <= sda_s;
         end
         if (qtr == 2'h3) begin
            bitn <= bitn + 4'h1;
         end
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rsp_valid_out   <= 1'h0;
         rsp_data_out    <= 8'h00;
         rsp_ack_bit_out <= 1'h1;
      end else begin
         rsp_valid_out <= done;
         if (done) begin
            rsp_data_out    <= shreg;
            rsp_ack_bit_out <= ack_bit;
         end
      end
   end

   assign link.host_scl_o    = 1'h0;
   assign link.host_scl_oe_n = scl_rel;
   assign link.host_sda_o    = 1'h0;
   assign link.host_sda_oe_n = ~sda_low;
endmodule // bus_master_end
`default_nettype wire

// ---- bench/eeprom_link_monitor.sv ----
// Checker for the two-wire link joining the master end and the EEPROM end.
// Sees the link lines, both data-line drive enables, the shared clock and its asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module eeprom_link_monitor (
   input  wire logic clk_in,
   input  wire logic nrst_in,
   input  wire logic scl_in,
   input  wire logic sda_in,
   input  wire logic host_sda_oe_n_in,
   input  wire logic dev_sda_oe_n_in
);
   // Short names for the watched lines keep the properties readable
   wire        scl           = scl_in;
   wire        sda           = sda_in;
   wire        host_sda_oe_n = host_sda_oe_n_in;
   wire        dev_sda_oe_n  = dev_sda_oe_n_in;
   logic       scl_q;
   logic       sda_q;
   logic [3:0] cnt;
   logic [1:0] byte_idx;
   logic [7:0] shreg;
   logic       rd;
   logic       nack_seen;
   wire        start_w  = scl & scl_q & sda_q & ~sda;
   wire        stop_w   = scl & scl_q & ~sda_q & sda;
   wire        rise_w   = scl & ~scl_q;
   wire        last_w   = (cnt == 4'h9);
   wire  [3:0] next_cnt = last_w ? 4'h1 : cnt + 4'h1;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         scl_q <= 1'h1;
         sda_q <= 1'h1;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end

   // Rising edges counted 1 to 9 per byte; a stop parks the count at zero.
   // A start or stop follows the first rise of a byte, so count 1 may carry one
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cnt      <= 4'h0;
         byte_idx <= 2'h0;
      end else if (start_w || stop_w) begin
         cnt      <= 4'h0;
         byte_idx <= 2'h0;
      end else if (rise_w) begin
         cnt <= next_cnt;
         if (last_w && byte_idx != 2'h3) begin
            byte_idx <= byte_idx + 2'h1;
         end
      end
   end

   // Direction is taken from the address word; only a read byte can be nacked by the master
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         shreg     <= 8'h00;
         rd        <= 1'h0;
         nack_seen <= 1'h0;
      end else if (start_w) begin
         nack_seen <= 1'h0;
      end else if (rise_w && next_cnt != 4'h9) begin
         shreg <= {shreg[6:0], sda};
      end else if (rise_w && byte_idx == 2'h0) begin
         rd <= shreg[0];
      end else if (rise_w && rd && sda) begin
         nack_seen <= 1'h1;
      end
   end

   dev_edge_lag_a: assert property (
      $changed(dev_sda_oe_n) |-> !$past(scl, 1) && !$past(scl, 2)
         && ($past(scl, 3) || $past(scl, 4) || $past(scl, 5)))
      else $error("device data line moved away from a clock fall");
   host_sda_hold_a: assert property (
      ($changed(host_sda_oe_n) && scl) |-> (cnt <= 4'h1))
      else $error("master moved data with clock high inside a byte");
   data_stable_a: assert property (
      (scl && scl_q && cnt > 4'h1) |-> $stable(sda))
      else $error("data line changed during clock high");
   addr_quiet_a: assert property (
      (scl && scl_q && byte_idx == 2'h0 && cnt != 4'h0 && !last_w) |-> dev_sda_oe_n)
      else $error("device drove during the address word");
   type_nack_a: assert property (
      (scl && scl_q && byte_idx == 2'h0 && last_w
         && shreg[7:4] != eeprom_pkg::DEVICE_TYPE_CODE) |-> dev_sda_oe_n)
      else $error("device acknowledged a foreign type code");
   ack_release_a: assert property (
      (scl && scl_q && last_w && !host_sda_oe_n) |-> dev_sda_oe_n)
      else $error("device held data during the master acknowledge");
   read_nack_quiet_a: assert property (
      nack_seen |-> dev_sda_oe_n)
      else $error("device drove after a read no-acknowledge");
   wr_ack_slot_a: assert property (
      (!dev_sda_oe_n && scl && scl_q && !(rd && byte_idx != 2'h0)) |-> last_w)
      else $error("device drove outside the acknowledge slot");
endmodule // eeprom_link_monitor
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench: master end and EEPROM end joined by the two-wire link.
// Drives the command port, straps and protect pin on falling clock edges.
`timescale 1ns/100ps
`default_nettype none
module tb;
   localparam int         PROG = 2000;
   localparam logic [2:0] SEL  = 3'h5;
   localparam logic [3:0] TYP  = eeprom_pkg::DEVICE_TYPE_CODE;
   localparam logic [7:0] AW   = {TYP, SEL, 1'h0};
   localparam logic [7:0] AR   = {TYP, SEL, 1'h1};
   // Address word beside the acknowledge bit it should draw
   localparam logic [8:0] ROWS [6] = '{{AW, 1'h0}, {TYP, SEL ^ 3'h1, 2'h1},
      {TYP, SEL ^ 3'h2, 2'h1}, {TYP, SEL ^ 3'h4, 2'h1}, {TYP ^ 4'h8, SEL, 2'h1},
      {TYP ^ 4'h1, SEL, 2'h3}};
   logic            clk_in;
   logic            nrst_in;
   logic [2:0]      sel_pins;
   logic            wp;
   logic            cmd_valid;
   logic            cmd_ready;
   eeprom_pkg::op_t cmd_op;
   logic [7:0]      cmd_data;
   logic            cmd_nack;
   logic            rsp_valid;
   logic [7:0]      rsp_data;
   logic            rsp_ack;
   logic            busy;
   logic [8:0]      wire_bits;
   int              errors;
   int              n_tests;
   int              busy_cnt;
   int              busy_len;
   int              polls;

   eeprom_link_if link ();

   eeprom_dev_end #(.PROG_CYCLES(PROG)) u_eeprom_dev_end (
      .clk_in             (clk_in),
      .nrst_in            (nrst_in),
      .select_pin_bit0_in (sel_pins[0]),
      .select_pin_bit1_in (sel_pins[1]),
      .select_pin_bit2_in (sel_pins[2]),
      .write_protect_in   (wp),
      .prog_busy_out      (busy),
      .link               (link.device)
   );
   bus_master_end u_bus_master_end (
      .clk_in          (clk_in),
      .nrst_in         (nrst_in),
      .cmd_valid_in    (cmd_valid),
      .cmd_ready_out   (cmd_ready),
      .cmd_op_in       (cmd_op),
      .cmd_data_in     (cmd_data),
      .cmd_nack_in     (cmd_nack),
      .rsp_valid_out   (rsp_valid),
      .rsp_data_out    (rsp_data),
      .rsp_ack_bit_out (rsp_ack),
      .link            (link.host)
   );
   eeprom_link_monitor u_eeprom_link_monitor (
      .clk_in        (clk_in),
      .nrst_in       (nrst_in),
      .scl_in           (link.scl),
      .sda_in           (link.sda),
      .host_sda_oe_n_in (link.host_sda_oe_n),
      .dev_sda_oe_n_in  (link.dev_sda_oe_n)
   );

   initial begin
      clk_in = 1'h0;
      forever #50 clk_in = ~clk_in;
   end

   // Last nine bits seen on the wire, so byte order is checked apart from the master
   always @(posedge link.scl) wire_bits <= {wire_bits[7:0], link.sda};

   always @(posedge clk_in) begin
      if (busy === 1'h1) begin
         busy_cnt <= busy_cnt + 1;
      end else if (busy_cnt != 0) begin
         busy_len <= busy_cnt;
         busy_cnt <= 0;
      end
   end

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", name, exp, got);
         errors++;
      end
   endtask

   task automatic finish_test();
      $display("checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic cmd(input eeprom_pkg::op_t op, input logic [7:0] d, input logic nk);
      int i;
      @(negedge clk_in);
      cmd_op    = op;
      cmd_data  = d;
      cmd_nack  = nk;
      cmd_valid = 1'h1;
      @(negedge clk_in);
      cmd_valid = 1'h0;
      for (i = 0; i < 400 && rsp_valid !== 1'h1; i++) begin
         @(negedge clk_in);
      end
      if (i == 400) begin
         errors++;
         finish_test();
      end
   endtask

   task automatic st();
      cmd(eeprom_pkg::OP_START, 8'h00, 1'h0);
   endtask

   task automatic sp();
      cmd(eeprom_pkg::OP_STOP, 8'h00, 1'h0);
   endtask

   task automatic wb(input logic [7:0] d, input logic ack);
      cmd(eeprom_pkg::OP_WRITE, d, 1'h0);
      chk("ack", 16'(ack), 16'(rsp_ack));
      chk("wire write", 16'({d, ack}), 16'(wire_bits));
   endtask

   task automatic rb(input logic [7:0] d, input logic nk);
      cmd(eeprom_pkg::OP_READ, 8'h00, nk);
      chk("read", 16'(d), 16'(rsp_data));
      chk("wire read", 16'({d, nk}), 16'(wire_bits));
   endtask

   task automatic seta(input logic [7:0] hi, input logic [7:0] lo);
      st();
      wb(AW, 1'h0);
      wb(hi, 1'h0);
      wb(lo, 1'h0);
   endtask

   initial begin
      errors    = 0;
      n_tests   = 0;
      polls     = 0;
      nrst_in   = 1'h0;
      sel_pins  = SEL;
      wp        = 1'h0;
      cmd_valid = 1'h0;
      cmd_op    = eeprom_pkg::OP_START;
      cmd_data  = 8'h00;
      cmd_nack  = 1'h0;
      repeat (3) @(negedge clk_in);
      chk("reset", 16'h000b, 16'({busy, cmd_ready, rsp_valid, rsp_ack, link.sda}));
      nrst_in = 1'h1;
      for (int r = 0; r < 6; r++) begin
         st();
         wb(ROWS[r][8:1], ROWS[r][0]);
         sp();
         chk("idle", 16'h0003, 16'({link.scl, link.sda}));
      end
      // Page write from offset 3e: the third byte wraps to the page start
      seta(8'hc1, 8'h3e);
      wb(8'h11, 1'h0);
      wb(8'h22, 1'h0);
      wb(8'h33, 1'h0);
      wb(8'h44, 1'h0);
      sp();
      chk("busy", 16'h0001, 16'(busy));
      st();
      wb(AW, 1'h1);
      do begin
         sp();
         st();
         cmd(eeprom_pkg::OP_WRITE, AW, 1'h0);
         polls++;
      end while (rsp_ack !== 1'h0 && polls < 20);
      chk("poll", 16'h0000, 16'(rsp_ack));
      chk("busy end", 16'h0000, 16'(busy));
      chk("cycle", 16'(PROG), 16'(busy_len));
      seta(8'h41, 8'h3e);
      st();
      wb(AR, 1'h0);
      rb(8'h11, 1'h0);
      rb(8'h22, 1'h1);
      sp();
      seta(8'h41, 8'h00);
      st();
      wb(AR, 1'h0);
      rb(8'h33, 1'h0);
      rb(8'h44, 1'h1);
      rb(8'hff, 1'h1);
      sp();
      // Protected array: addresses acked, data refused, nothing programmed
      wp = 1'h1;
      seta(8'h41, 8'h00);
      wb(8'h5a, 1'h1);
      sp();
      repeat (10) @(negedge clk_in);
      chk("wp busy", 16'h0000, 16'(busy));
      seta(8'h41, 8'h00);
      st();
      wb(AR, 1'h0);
      rb(8'h33, 1'h1);
      sp();
      wp = 1'h0;
      // Reset in mid-programming must free the line and the device
      seta(8'h00, 8'h00);
      wb(8'h99, 1'h0);
      sp();
      chk("busy2", 16'h0001, 16'(busy));
      nrst_in = 1'h0;
      @(negedge clk_in);
      chk("mid reset", 16'h0003, 16'({busy, cmd_ready, link.dev_sda_oe_n}));
      // Two edges in reset; both synchroniser stages already cleared at once on the asynchronous reset
      @(negedge clk_in);
      nrst_in = 1'h1;
      st();
      wb(AW, 1'h0);
      sp();
      finish_test();
   end
endmodule // tb
`default_nettype wire
